// ==== include/copx_pkg.sv ====
// Package for the custom operation port unit.
// Assumes a single clock domain; shared by all design files.
package copx_pkg;
  localparam int unsigned OP_W      = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned IDX_W     = 5;
  localparam int unsigned RF_DEPTH  = 32;
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned MUL_CYC   = 4;
  localparam logic [2:0]  CNT_RST   = 3'h0;
  localparam logic [31:0] WORD_RST  = 32'h0;
  // Operation codes on op_select
  localparam logic [7:0] OP_PASS    = 8'h00;
  localparam logic [7:0] OP_BITSWAP = 8'h01;
  localparam logic [7:0] OP_BYTESW  = 8'h02;
  localparam logic [7:0] OP_HALFSW  = 8'h03;
  localparam logic [7:0] OP_ADD     = 8'h04;
  localparam logic [7:0] OP_MAC     = 8'h05;
  localparam logic [7:0] OP_MEMWR   = 8'h06;
  localparam logic [7:0] OP_MEMRD   = 8'h07;
  // AXI4-Lite register map (byte addresses)
  localparam logic [ADDR_W-1:0] REG_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] REG_ACC    = 12'h008;
  localparam logic [ADDR_W-1:0] REG_COUNT  = 12'h00C;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] CTRL_RST   = 32'h0;
  typedef enum logic [1:0] {COPX_IDLE, COPX_BUSY, COPX_DONE} copx_state_e;
endpackage : copx_pkg

// ==== logic/copx_regfile.sv ====
// Local register file: 32 words, two read ports, one write port.
// Assumes writes arrive already qualified by the cycle qualifier.
`timescale 1ns/1ps
module copx_regfile
  import copx_pkg::*;
(
  // Clock
  input  wire logic              aclk,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [IDX_W-1:0]  wr_idx,
  input  wire logic [DATA_W-1:0] wr_data,
  // Read ports
  input  wire logic [IDX_W-1:0]  rd_a_idx,
  input  wire logic [IDX_W-1:0]  rd_b_idx,
  output logic      [DATA_W-1:0] rd_a_data,
  output logic      [DATA_W-1:0] rd_b_data
);
  logic [DATA_W-1:0] mem [RF_DEPTH];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data; // RQ18
    end
  end

  assign rd_a_data = mem[rd_a_idx];
  assign rd_b_data = mem[rd_b_idx];
endmodule : copx_regfile

// ==== logic/copx_axil.sv ====
// AXI4-Lite slave for the unit's control and status words.
// Assumes one outstanding write and one outstanding read.
`timescale 1ns/1ps
module copx_axil
  import copx_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write channels
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // Read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Block side
  output logic [31:0]            ctrl_word,
  input  wire logic [31:0]       status_word,
  input  wire logic [31:0]       acc_word,
  input  wire logic [31:0]       count_word
);
  logic              aw_have_r, aw_have_nxt;
  logic              w_have_r, w_have_nxt;
  logic [ADDR_W-1:0] aw_r, aw_nxt;
  logic [31:0]       wd_r, wd_nxt;
  logic [3:0]        ws_r, ws_nxt;
  logic [31:0]       ctrl_r, ctrl_nxt;
  logic              bv_r, bv_nxt;
  logic [1:0]        br_r, br_nxt;
  logic              rv_r, rv_nxt;
  logic [31:0]       rd_r, rd_nxt;
  logic [1:0]        rr_r, rr_nxt;

  assign awready   = !aw_have_r && !bv_r;
  assign wready    = !w_have_r && !bv_r;
  assign arready   = !rv_r;
  assign bvalid    = bv_r;
  assign bresp     = br_r;
  assign rvalid    = rv_r;
  assign rdata     = rd_r;
  assign rresp     = rr_r;
  assign ctrl_word = ctrl_r;

  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt  = w_have_r;
    aw_nxt      = aw_r;
    wd_nxt      = wd_r;
    ws_nxt      = ws_r;
    ctrl_nxt    = ctrl_r;
    bv_nxt      = bv_r;
    br_nxt      = br_r;
    rv_nxt      = rv_r;
    rd_nxt      = rd_r;
    rr_nxt      = rr_r;
    if (awvalid && awready) begin
      aw_have_nxt = 1'b1;
      aw_nxt      = awaddr;
    end
    if (wvalid && wready) begin
      w_have_nxt = 1'b1;
      wd_nxt     = wdata;
      ws_nxt     = wstrb;
    end
    if (aw_have_r && w_have_r) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bv_nxt      = 1'b1;
      br_nxt      = RESP_SLVERR;
      if ({aw_r[ADDR_W-1:2], 2'h0} == REG_CTRL) begin
        br_nxt = RESP_OKAY;
        for (int i = 0; i < 4; i++) begin
          if (ws_r[i]) begin
            ctrl_nxt[i*8 +: 8] = wd_r[i*8 +: 8];
          end
        end
      end else if ({aw_r[ADDR_W-1:2], 2'h0} == REG_STATUS ||
                   {aw_r[ADDR_W-1:2], 2'h0} == REG_ACC ||
                   {aw_r[ADDR_W-1:2], 2'h0} == REG_COUNT) begin
        br_nxt = RESP_OKAY;
      end
    end
    if (bv_r && bready) begin
      bv_nxt = 1'b0;
    end
    if (arvalid && arready) begin
      rv_nxt = 1'b1;
      rr_nxt = RESP_OKAY;
      unique case ({araddr[ADDR_W-1:2], 2'h0})
        REG_CTRL:   rd_nxt = ctrl_r;
        REG_STATUS: rd_nxt = status_word;
        REG_ACC:    rd_nxt = acc_word;
        REG_COUNT:  rd_nxt = count_word;
        default: begin
          rd_nxt = WORD_RST;
          rr_nxt = RESP_SLVERR;
        end
      endcase
    end else if (rv_r && rready) begin
      rv_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_r      <= '0;
      wd_r      <= WORD_RST;
      ws_r      <= 4'h0;
      ctrl_r    <= CTRL_RST;
      bv_r      <= 1'b0;
      br_r      <= RESP_OKAY;
      rv_r      <= 1'b0;
      rd_r      <= WORD_RST;
      rr_r      <= RESP_OKAY;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      aw_r      <= aw_nxt;
      wd_r      <= wd_nxt;
      ws_r      <= ws_nxt;
      ctrl_r    <= ctrl_nxt;
      bv_r      <= bv_nxt;
      br_r      <= br_nxt;
      rv_r      <= rv_nxt;
      rd_r      <= rd_nxt;
      rr_r      <= rr_nxt;
    end
  end
endmodule : copx_axil

// ==== logic/copx_unit.sv ====
// Multi-cycle user operation unit with selector, local registers
// and an exported buffer-memory port. Assumes the core holds all
// instruction inputs stable from start until done.
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: op_select steers the result multiplexer
// RQ2: Multi-cycle build; selector is only addition (here op_select picks among eight operations)
// RQ3: Selector width set by operation count
// RQ4: Core holds op_select from start to done
// RQ5: Source and destination flags pick register file
// RQ6: Low first flag reads local entry
// RQ7: Three indexes address local register file
// RQ8: Destination flag writes result locally
// RQ9: Core holds flags and indexes stable
// RQ10: Index ignored when its source is core
// RQ11: Core drops result when dest_select low
// RQ12: Foreign ports exported to system top
// RQ13: Exported port moves data to buffer
// RQ14: Only multi-cycle units export ports
// RQ15: Result valid on the done edge
// RQ16: Edges with cycle_qualifier low ignored
// RQ17: Selector field up to 256 operations
// RQ18: Thirty-two local 32-bit entries, two reads
module copx_unit
  import copx_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Instruction interface
  input  wire logic              cycle_qualifier,
  input  wire logic              start,
  output logic                   done,
  input  wire logic [OP_W-1:0]   op_select,
  input  wire logic [DATA_W-1:0] first_operand,
  input  wire logic [DATA_W-1:0] second_operand,
  output logic      [DATA_W-1:0] result,
  input  wire logic              first_source_from_cpu,
  input  wire logic              second_source_from_cpu,
  input  wire logic              dest_select,
  input  wire logic [IDX_W-1:0]  first_source_index,
  input  wire logic [IDX_W-1:0]  second_source_index,
  input  wire logic [IDX_W-1:0]  destination_index,
  // Exported buffer interface
  output logic                   buf_valid,
  input  wire logic              buf_ready,
  output logic                   buf_write,
  output logic      [DATA_W-1:0] buf_wdata,
  input  wire logic [DATA_W-1:0] buf_rdata,
  // AXI4-Lite register bus
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready
);
  copx_state_e       st_r, st_nxt;
  logic [2:0]        cnt_r, cnt_nxt;
  logic [DATA_W-1:0] res_r, res_nxt;
  logic [DATA_W-1:0] acc_r, acc_nxt;
  logic [DATA_W-1:0] ops_r, ops_nxt;
  logic              bv_r, bv_nxt;
  logic [DATA_W-1:0] bw_r, bw_nxt;
  logic              bwr_r, bwr_nxt;
  logic              done_r, done_nxt;
  logic              rf_we;
  logic [DATA_W-1:0] rf_a, rf_b, opa, opb;
  logic [31:0]       ctrl_word;
  logic              enable;

  function automatic logic [31:0] swap_bits(input logic [31:0] v);
    for (int i = 0; i < 32; i++) begin
      swap_bits[i] = v[31-i];
    end
  endfunction : swap_bits

  copx_regfile i_copx_regfile (
    .aclk      (aclk),
    .wr_en     (rf_we),
    .wr_idx    (destination_index),
    .wr_data   (res_nxt),
    .rd_a_idx  (first_source_index),
    .rd_b_idx  (second_source_index),
    .rd_a_data (rf_a),
    .rd_b_data (rf_b)
  );

  copx_axil i_copx_axil (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .awaddr      (awaddr),
    .awvalid     (awvalid),
    .awready     (awready),
    .wdata       (wdata),
    .wstrb       (wstrb),
    .wvalid      (wvalid),
    .wready      (wready),
    .bresp       (bresp),
    .bvalid      (bvalid),
    .bready      (bready),
    .araddr      (araddr),
    .arvalid     (arvalid),
    .arready     (arready),
    .rdata       (rdata),
    .rresp       (rresp),
    .rvalid      (rvalid),
    .rready      (rready),
    .ctrl_word   (ctrl_word),
    .status_word ({28'h0, bv_r, done_r, st_r == COPX_BUSY, enable}),
    .acc_word    (acc_r),
    .count_word  (ops_r)
  );

  // Control bit 0 high stops new operations from starting; a busy one still completes
  assign enable = !ctrl_word[0];

  // Operand source selection; index ignored when core supplies it
  assign opa = first_source_from_cpu ? first_operand : rf_a;  // RQ5 RQ6 RQ10
  assign opb = second_source_from_cpu ? second_operand : rf_b; // RQ5 RQ10

  assign done      = done_r;
  assign result    = res_r; // RQ15
  assign buf_valid = bv_r;
  assign buf_write = bwr_r;
  assign buf_wdata = bw_r;  // RQ12 RQ13

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    res_nxt  = res_r;
    acc_nxt  = acc_r;
    ops_nxt  = ops_r;
    bv_nxt   = bv_r;
    bw_nxt   = bw_r;
    bwr_nxt  = bwr_r;
    done_nxt = done_r;
    rf_we    = 1'b0;
    if (cycle_qualifier) begin // RQ16
      unique case (st_r)
        COPX_IDLE: begin
          done_nxt = 1'b0;
          if (start && enable) begin
            st_nxt  = COPX_BUSY;
            cnt_nxt = CNT_RST;
            if (op_select == OP_MEMWR || op_select == OP_MEMRD) begin
              bv_nxt  = 1'b1;
              bwr_nxt = op_select == OP_MEMWR;
              bw_nxt  = opa; // RQ13
            end
          end
        end
        COPX_BUSY: begin
          cnt_nxt = cnt_r + 3'h1;
          if (bv_r && buf_ready) begin
            bv_nxt = 1'b0;
          end
          // Result multiplexer; selector held by core
          if (!bv_r && cnt_r >= 3'(MUL_CYC - 1)) begin
            unique case (op_select) // RQ1 RQ3 RQ17
              OP_PASS:    res_nxt = opa;
              OP_BITSWAP: res_nxt = swap_bits(opa);
              OP_BYTESW:  res_nxt = {opa[7:0], opa[15:8],
                                     opa[23:16], opa[31:24]};
              OP_HALFSW:  res_nxt = {opa[15:0], opa[31:16]};
              OP_ADD:     res_nxt = opa + opb;
              OP_MAC: begin
                res_nxt = acc_r + DATA_W'(opa * opb);
                acc_nxt = res_nxt;
              end
              OP_MEMWR:   res_nxt = bw_r;
              OP_MEMRD:   res_nxt = buf_rdata;
              default:    res_nxt = WORD_RST;
            endcase
            rf_we    = dest_select; // RQ8 RQ7
            ops_nxt  = ops_r + 32'h1;
            done_nxt = 1'b1;
            st_nxt   = COPX_DONE;
          end
        end
        COPX_DONE: begin
          done_nxt = 1'b0;
          st_nxt   = COPX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r   <= COPX_IDLE;
      cnt_r  <= CNT_RST;
      res_r  <= WORD_RST;
      acc_r  <= WORD_RST;
      ops_r  <= WORD_RST;
      bv_r   <= 1'b0;
      bw_r   <= WORD_RST;
      bwr_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      res_r  <= res_nxt;
      acc_r  <= acc_nxt;
      ops_r  <= ops_nxt;
      bv_r   <= bv_nxt;
      bw_r   <= bw_nxt;
      bwr_r  <= bwr_nxt;
      done_r <= done_nxt;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  done_pulse_a: assert property (done && cycle_qualifier |=> !done) // RQ15
    else $error("done held longer than one cycle");
  result_swap_a: assert property ( // RQ1
    done && $past(op_select) == OP_HALFSW && $past(cycle_qualifier)
    |-> result == {$past(opa[15:0]), $past(opa[31:16])})
    else $error("half swap result wrong");
  qual_hold_a: assert property ( // RQ16
    !cycle_qualifier |=> $stable(st_r) && $stable(res_r))
    else $error("state moved on a disqualified edge");
  busy_bound_a: assert property ( // RQ2
    start && enable && st_r == COPX_IDLE && cycle_qualifier && !bv_nxt
    ##1 cycle_qualifier [*4] |=> done)
    else $error("done not within four cycles");
  rf_write_a: assert property ( // RQ8
    rf_we |-> dest_select && cycle_qualifier && done_nxt)
    else $error("local write without destination flag");
  src_local_a: assert property ( // RQ6
    !first_source_from_cpu |-> opa == rf_a)
    else $error("first operand not from local file");
  src_cpu_a: assert property ( // RQ10
    second_source_from_cpu |-> opb == second_operand)
    else $error("second index not disregarded");
  acc_only_mac_a: assert property ( // RQ7
    $changed(acc_r) |-> $past(op_select) == OP_MAC)
    else $error("accumulator changed by another operation");
  buf_hold_a: assert property ( // RQ13
    buf_valid && !buf_ready |=> buf_valid && $stable(buf_wdata))
    else $error("buffer request dropped before ready");
  sel_range_a: assert property ( // RQ3
    done && $past(op_select) > OP_MEMRD |-> result == WORD_RST)
    else $error("unused selector gave nonzero result");
  // Result multiplexer, one check per operation family
  pass_result_a: assert property ( // RQ1
    $rose(done) && $past(op_select) == OP_PASS
    |-> result == $past(opa))
    else $error("pass result wrong");
  bit_rev_a: assert property ( // RQ1
    $rose(done) && $past(op_select) == OP_BITSWAP
    |-> result[31] == $past(opa[0]) && result[0] == $past(opa[31]))
    else $error("bit reverse result wrong");
  byte_swap_a: assert property ( // RQ1
    $rose(done) && $past(op_select) == OP_BYTESW
    |-> result[7:0] == $past(opa[31:24]) &&
        result[31:24] == $past(opa[7:0]))
    else $error("byte swap result wrong");
  add_result_a: assert property ( // RQ1
    $rose(done) && $past(op_select) == OP_ADD
    |-> result == $past(opa) + $past(opb))
    else $error("addition result wrong");
  mac_result_a: assert property ( // RQ1
    $rose(done) && $past(op_select) == OP_MAC
    |-> result == $past(acc_r) + $past(opa) * $past(opb))
    else $error("multiply accumulate result wrong");
  buf_read_a: assert property ( // RQ13
    $rose(done) && $past(op_select) == OP_MEMRD
    |-> result == $past(buf_rdata))
    else $error("buffer read result wrong");
  // Handshake, hold and local write checks
  rf_store_a: assert property ( // RQ8 RQ18
    rf_we |=> i_copx_regfile.mem[destination_index] == result)
    else $error("local entry not written with result");
  buf_release_a: assert property ( // RQ13
    buf_valid && buf_ready && cycle_qualifier |=> !buf_valid)
    else $error("buffer request held after ready");
  result_hold_a: assert property ( // RQ15
    $changed(result) |-> $rose(done))
    else $error("result changed without done");
  done_source_a: assert property ( // RQ15
    $rose(done) |-> $past(st_r) == COPX_BUSY)
    else $error("done raised outside busy state");
  done_stall_a: assert property ( // RQ16
    done && !cycle_qualifier |=> done)
    else $error("done dropped on a disqualified edge");

  op_mac_c:   cover property (done && op_select == OP_MAC);
  local_wr_c: cover property (rf_we);
  buf_wr_c:   cover property (buf_valid && buf_ready && buf_write);
  stall_c:    cover property (st_r == COPX_BUSY && !cycle_qualifier);
  done_hold_c: cover property (done && !cycle_qualifier);
endmodule : copx_unit

// ==== test/copx_bufmem.sv ====
// Buffer memory model on the exported port of the operation unit.
// Assumes the unit holds buf_valid until it samples buf_ready.
`timescale 1ns/1ps
module copx_bufmem (
  // Clock
  input  wire logic        aclk,
  // Buffer handshake
  input  wire logic        buf_valid,
  output logic             buf_ready,
  input  wire logic        buf_write,
  input  wire logic [31:0] buf_wdata,
  output logic [31:0]      buf_rdata,
  // Stall length in cycles
  input  wire logic [3:0]  lat
);
  logic [31:0] mem_r = 32'h0;
  logic [3:0]  wait_r = 4'h0;
  logic        rdy_r = 1'b0;

  assign buf_ready = rdy_r;
  assign buf_rdata = mem_r;

  // Ready stays up until the unit drops its request
  always @(posedge aclk) begin
    if (buf_valid !== 1'b1) begin
      rdy_r <= 1'b0;
      wait_r <= 4'h0;
    end else if (wait_r < lat) begin
      wait_r <= wait_r + 4'h1;
    end else begin
      rdy_r <= 1'b1;
      if (rdy_r == 1'b0 && buf_write === 1'b1)
        mem_r <= buf_wdata;
    end
  end
endmodule : copx_bufmem

// ==== test/tb_copx_unit.sv ====
// Self-checking bench for the custom operation unit.
// Assumes the buffer model on the exported port and 50 ns clock.
`timescale 1ns/1ps
module tb_copx_unit
  import copx_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, cycle_qualifier = 1'b1, start = 1'b0;
  logic [OP_W-1:0] op_select = 8'h00;
  logic [DATA_W-1:0] first_operand = 32'h0, second_operand = 32'h0;
  logic first_source_from_cpu = 1'b1, second_source_from_cpu = 1'b1;
  logic dest_select = 1'b0, done, buf_valid, buf_ready, buf_write;
  logic [IDX_W-1:0] first_source_index = 5'h0, second_source_index = 5'h0;
  logic [IDX_W-1:0] destination_index = 5'h0;
  logic [DATA_W-1:0] result, buf_wdata, buf_rdata;
  logic [3:0] lat = 4'h0, wstrb = 4'hF;
  logic [ADDR_W-1:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, awready, wready;
  logic arvalid = 1'b0, rready = 1'b0, arready, bvalid, rvalid;
  logic [31:0] wdata = 32'h0, rdata, e_res, acc_exp = 32'h0;
  logic [31:0] buf_exp = 32'h0, x1, x2, a, b;
  logic [1:0] bresp, rresp, e_b;
  logic [34:0] e_rd;
  logic [7:0] sel;
  logic [31:0] q_res[$];
  logic [34:0] q_rd[$];
  logic [1:0] q_b[$];
  int errors = 0, checks_done = 0, seed = 53640, cnt_exp = 0;
  logic qmode = 1'b0;

  copx_unit i_copx_unit (
    .aclk, .aresetn, .cycle_qualifier, .start, .done, .op_select,
    .first_operand, .second_operand, .result, .first_source_from_cpu,
    .second_source_from_cpu, .dest_select, .first_source_index,
    .second_source_index, .destination_index, .buf_valid, .buf_ready,
    .buf_write, .buf_wdata, .buf_rdata, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
  );
  copx_bufmem i_copx_bufmem (
    .aclk, .buf_valid, .buf_ready, .buf_write, .buf_wdata, .buf_rdata, .lat
  );

  initial begin
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (qmode) cycle_qualifier <= ($random(seed) & 3) != 0;
    else cycle_qualifier <= 1'b1;
  end

  task automatic fail(input string msg);
    $display("MISMATCH t=%0t %s", $time, msg);
    errors++;
  endtask : fail

  task automatic end_of_test;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic qwait(input int k);
    int n;
    n = 0;
    while (k > 0) begin
      @(posedge aclk);
      if (cycle_qualifier === 1'b1) k--;
      n++;
      if (n > 400) begin
        fail("timeout");
        end_of_test();
      end
    end
  endtask : qwait

  function automatic logic [31:0] model(input logic [7:0] s,
                                        input logic [31:0] p, q);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) r[i] = p[31-i];
    case (s)
      OP_PASS:    return p;
      OP_BITSWAP: return r;
      OP_BYTESW:  return {p[7:0], p[15:8], p[23:16], p[31:24]};
      OP_HALFSW:  return {p[15:0], p[31:16]};
      OP_ADD:     return p + q;
      OP_MAC:     return acc_exp + p * q;
      OP_MEMWR:   return p;
      OP_MEMRD:   return buf_exp;
      default:    return 32'h0;
    endcase
  endfunction : model

  // One instruction, held from start until done
  task automatic op(input logic [7:0] s, input logic [31:0] p, q,
                    input logic [2:0] fl, input logic [14:0] ix,
                    input logic [31:0] ex);
    @(posedge aclk);
    q_res.push_back(ex);
    if (s == OP_MAC) acc_exp = ex;
    if (s == OP_MEMWR) buf_exp = p;
    op_select <= s;
    first_operand <= p;
    second_operand <= q;
    {first_source_from_cpu, second_source_from_cpu, dest_select} <= fl;
    {first_source_index, second_source_index, destination_index} <= ix;
    lat <= 4'($random(seed) & 7);
    start <= 1'b1;
    qwait(1);
    start <= 1'b0;
    qwait(1);
    for (int n = 0; done !== 1'b1 || cycle_qualifier !== 1'b1; n++) begin
      if (n > 400) begin
        fail("done timeout");
        end_of_test();
      end
      qwait(1);
    end
    cnt_exp++;
    qwait(2);
  endtask : op

  task automatic axi_wr(input logic [11:0] ad, input logic [31:0] d,
                        input logic [1:0] rsp);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    q_b.push_back(rsp);
    awaddr <= ad;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    for (int n = 0; n < 100; n++) begin
      @(negedge aclk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) begin
        bready <= 1'b0;
        return;
      end
    end
    fail("write timeout");
    end_of_test();
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] ad, input logic [31:0] d,
                        input logic [1:0] rsp);
    logic ar_t, r_t;
    @(posedge aclk);
    q_rd.push_back({rsp == RESP_OKAY, rsp, d});
    araddr <= ad;
    {arvalid, rready} <= 2'h3;
    for (int n = 0; n < 100; n++) begin
      @(negedge aclk);
      ar_t = arvalid & arready;
      r_t = rvalid;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) begin
        rready <= 1'b0;
        return;
      end
    end
    fail("read timeout");
    end_of_test();
  endtask : axi_rd

  // Compares each result against the oldest note
  always @(posedge aclk) begin
    if (aresetn && done === 1'b1 && cycle_qualifier === 1'b1) begin
      checks_done++;
      if (q_res.size() == 0) fail("unexpected done");
      else begin
        e_res = q_res.pop_front();
        if (result !== e_res) fail("result");
      end
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      checks_done++;
      e_rd = q_rd.pop_front();
      if (rresp !== e_rd[33:32] || (e_rd[34] && rdata !== e_rd[31:0]))
        fail("read data");
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      checks_done++;
      e_b = q_b.pop_front();
      if (bresp !== e_b) fail("write response");
    end
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(REG_CTRL, CTRL_RST, RESP_OKAY);
    axi_rd(REG_ACC, WORD_RST, RESP_OKAY);
    axi_rd(12'h010, 32'h0, RESP_SLVERR);
    axi_wr(12'h010, 32'h5A5A5A5A, RESP_SLVERR);
    for (int k = 0; k < 2; k++) begin
      qmode <= k[0];
      for (int s = 0; s < 9; s++) begin
        sel = (s == 8) ? 8'hFF : 8'(s);
        a = $random(seed);
        b = $random(seed);
        op(sel, a, b, 3'b110, 15'($random(seed)), model(sel, a, b));
      end
    end
    x1 = $random(seed);
    x2 = $random(seed);
    op(OP_PASS, x1, 32'h0, 3'b111, {10'h0, 5'd31}, x1);
    op(OP_PASS, x2, 32'h0, 3'b111, {10'h3FF, 5'd0}, x2);
    op(OP_PASS, 32'h0, 32'h0, 3'b010, {5'd31, 10'h0}, x1);
    op(OP_ADD, 32'h0, 32'h0, 3'b000, {5'd31, 5'd0, 5'd9}, x1 + x2);
    op(OP_ADD, 32'h3, 32'h4, 3'b110, {5'd31, 5'd0, 5'd9}, 32'h7);
    axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
    axi_rd(REG_CTRL, 32'h1, RESP_OKAY);
    @(posedge aclk);
    start <= 1'b1;
    qwait(6);
    start <= 1'b0;
    axi_rd(REG_STATUS, 32'h0, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
    axi_wr(REG_COUNT, 32'hFFFF, RESP_OKAY);
    axi_rd(REG_COUNT, 32'(cnt_exp), RESP_OKAY);
    axi_rd(REG_ACC, acc_exp, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h1, RESP_OKAY);
    end_of_test();
  end
endmodule : tb_copx_unit
